// ### src/flash_protect_pkg.sv
package flash_protect_pkg;

  // Register offsets (plain port, byte-wide registers)
  localparam logic [3:0] OffStatus = 4'h0;
  localparam logic [3:0] OffIndex = 4'h1;
  localparam logic [3:0] OffProgProt = 4'h2;
  localparam logic [3:0] OffDataProt = 4'h3;
  localparam logic [3:0] OffCmdHi = 4'h4;
  localparam logic [3:0] OffCmdLo = 4'h5;
  localparam logic [3:0] OffRsvA = 4'h6;
  localparam logic [3:0] OffRsvB = 4'h7;
  localparam logic [3:0] OffRsvC = 4'h8;
  localparam logic [3:0] OffRsvD = 4'h9;
  localparam logic [3:0] OffCtrl = 4'ha;

  // Status register fields
  localparam int StatCcifBit = 7;
  localparam int StatViolBit = 5;

  // Control register fields
  localparam int CtrlReqBit = 0;
  localparam int CtrlBlkBit = 1;
  localparam int CtrlDataBit = 2;

  // Program-flash protection fields
  localparam int PpModeBit = 7;
  localparam int PpHiDisBit = 5;
  localparam int PpLoDisBit = 2;
  localparam int PpHiSizeLsb = 3;
  localparam int PpLoSizeLsb = 0;
  localparam logic [7:0] PpWritableMask = 8'hbf;
  localparam logic [7:0] PpResetValue = 8'hff;
  localparam logic [7:0] PpFaultValue = 8'h7f;

  // Data-flash protection fields
  localparam int DpOffBit = 7;
  localparam int DpSizeLsb = 0;
  localparam logic [7:0] DpFaultValue = 8'h0f;
  localparam logic [7:0] DpWritableMask = 8'h8f;

  // Protected data-flash window
  localparam logic [17:0] DataFlashBase = 18'h04400;
  localparam logic [17:0] DataFlashEnd = 18'h053ff;
  localparam int DataSectorShift = 8;

  // Command array
  localparam int CmdWords = 6;
  localparam int CmdIndexWidth = 3;

  typedef struct packed {
    logic [7:0] code;
    logic [17:0] addr;
    logic [15:0] data0;
  } cmd_launch_t;

  typedef struct packed {
    logic valid;
    logic [CmdIndexWidth-1:0] index;
    logic [15:0] data;
  } cmd_result_t;

endpackage : flash_protect_pkg

// ### src/cmd_word_mem.sv
module cmd_word_mem #(
  parameter int Words = 6,
  parameter int Width = 16,
  parameter int AddrWidth = 3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [AddrWidth-1:0] wrAddr,
  input wire logic [1:0] wrByteEn,
  input wire logic [Width-1:0] wrData,
  input wire logic [AddrWidth-1:0] rdAddr,
  output logic [Width-1:0] rdData,
  output logic [Words*Width-1:0] allWords
);

  if (Width != 16 || Words > (1 << AddrWidth)) begin : g_bad_geometry
    $error("cmd_word_mem: unsupported geometry");
  end

  logic [Width-1:0] mem_q [Words];

  for (genvar w = 0; w < Words; w++) begin : g_word
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        mem_q[w] <= '0;
      end else if (wrAddr == AddrWidth'(w)) begin
        if (wrByteEn[1]) begin
          mem_q[w][15:8] <= wrData[15:8];
        end
        if (wrByteEn[0]) begin
          mem_q[w][7:0] <= wrData[7:0];
        end
      end
    end
    assign allWords[w*Width +: Width] = mem_q[w];
  end

  // Unimplemented entries read as zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData <= '0;
    end else if (rdAddr < AddrWidth'(Words)) begin
      rdData <= mem_q[rdAddr];
    end else begin
      rdData <= '0;
    end
  end

endmodule : cmd_word_mem

// ### src/flash_protect_and_cmd_regs.sv
// Functional notes
// - Program-flash protection may only tighten; bad writes are dropped.
// - Scenario transitions follow the fixed allowed-transition table.
// - Program-flash protection readback shows the scenario in force.
// - Data-flash size only grows; protect-off only goes 1 to 0.
// - With protect-off set, size is ignored and data-flash is open.
// - Protect-off is bit 7; 0 protects, 1 unprotects.
// - Size bits 3:0 protect 0x0_4400 for (size+1)*256 bytes.
// - Data-flash protection loads from configuration byte at reset.
// - Config double-bit fault: protect-off cleared, size bits all set.
// - Program/erase into protected data-flash refused, violation flag set.
// - Data-flash block erase refused while any sector is protected.
// - Command object: six 16-bit words by 3-bit index, byte access.
// - Writing 1 to complete flag clears it and launches parameters.
// - Parameters locked while complete flag is 0; controller sets it.
// - Results land in the array, readable once complete flag is 1.
// - Indices 6 and 7: writes ignored, reads return zero.
// - Four reserved test registers read zero and ignore writes.
// - Program protect: bit 7 mode, 5/4:3 high range, 2/1:0 low range.
// - Range size fields writable only while their disable bit is set.
// - Alteration of protected program-flash refused, violation flag set.
module flash_protect_and_cmd_regs #(
  parameter logic [17:0] ProgHiBase = 18'h38000,
  parameter logic [17:0] ProgTop = 18'h3ffff
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic cfgValid,
  input wire logic [7:0] cfgProgProt,
  input wire logic [7:0] cfgDataProt,
  input wire logic cfgFault,
  output logic cmdLaunch,
  output flash_protect_pkg::cmd_launch_t cmdParams,
  output logic cmdRefused,
  input wire flash_protect_pkg::cmd_result_t cmdResult,
  input wire logic cmdDone,
  output logic [7:0] progProtect,
  output logic [7:0] dataProtect,
  output logic commandComplete
);

  localparam int Iw = flash_protect_pkg::CmdIndexWidth;
  localparam int Nw = flash_protect_pkg::CmdWords;

  if (ProgHiBase > ProgTop) begin : g_bad_range
    $error("flash_protect_and_cmd_regs: bad program-flash range");
  end

  logic [7:0] progProt_q;
  logic [7:0] dataProt_q;
  logic [Iw-1:0] index_q;
  logic command_complete_flag_q;
  logic viol_q;
  logic [7:0] ctrl_q;
  logic cmdLaunch_q;
  logic cmdRefused_q;
  flash_protect_pkg::cmd_launch_t cmdParams_q;
  logic [7:0] rdData_q;
  logic rdPending_q;
  logic rdHighByte_q;
  logic [3:0] rdAddr_q;
  logic [15:0] memRd;
  logic [Nw*16-1:0] memAll;

  logic wrHit;
  assign wrHit = regWrite;

  function automatic logic [2:0] scenario(input logic [7:0] v);
    scenario = {v[flash_protect_pkg::PpModeBit],
                v[flash_protect_pkg::PpHiDisBit],
                v[flash_protect_pkg::PpLoDisBit]};
  endfunction : scenario

  // Allowed-transition rows, bit n set when target n is legal
  function automatic logic allowed(input logic [2:0] from,
                                   input logic [2:0] to);
    logic [7:0] row;
    row = 8'h00;
    unique case (from)
      3'h0: row = 8'h0f;
      3'h1: row = 8'h0a;
      3'h2: row = 8'h0c;
      3'h3: row = 8'h08;
      3'h4: row = 8'h18;
      3'h5: row = 8'h3c;
      3'h6: row = 8'h5a;
      3'h7: row = 8'hff;
    endcase
    allowed = row[to];
  endfunction : allowed

  // Program-flash protection candidate with size-field gating
  logic [7:0] ppCand;
  always_comb begin
    ppCand = (regWrData & flash_protect_pkg::PpWritableMask)
           | (progProt_q & ~flash_protect_pkg::PpWritableMask);
    if (!progProt_q[flash_protect_pkg::PpHiDisBit]) begin
      ppCand[4:3] = progProt_q[4:3];
    end
    if (!progProt_q[flash_protect_pkg::PpLoDisBit]) begin
      ppCand[1:0] = progProt_q[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      progProt_q <= flash_protect_pkg::PpResetValue;
    end else if (cfgValid) begin
      progProt_q <= cfgFault ? flash_protect_pkg::PpFaultValue
                             : cfgProgProt;
    end else if (wrHit && regAddr == flash_protect_pkg::OffProgProt
                 && allowed(scenario(progProt_q), scenario(ppCand))) begin
      progProt_q <= ppCand;
    end
  end

  // Data-flash protection: reset load, fault fallback, tighten only
  logic [7:0] dpCand;
  logic dpOk;
  always_comb begin
    dpCand = regWrData & flash_protect_pkg::DpWritableMask;
    dpOk = 1'b1;
    if (dpCand[flash_protect_pkg::DpOffBit]
        && !dataProt_q[flash_protect_pkg::DpOffBit]) begin
      dpOk = 1'b0;
    end
    if (dpCand[3:0] < dataProt_q[3:0]) begin
      dpOk = 1'b0;
    end
    if (dpCand == dataProt_q) begin
      dpOk = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dataProt_q <= flash_protect_pkg::DpFaultValue;
    end else if (cfgValid) begin
      if (cfgFault) begin
        dataProt_q <= flash_protect_pkg::DpFaultValue;
      end else begin
        dataProt_q <= cfgDataProt
                    & flash_protect_pkg::DpWritableMask;
      end
    end else if (wrHit && regAddr == flash_protect_pkg::OffDataProt
                 && dpOk) begin
      dataProt_q <= dpCand;
    end
  end

  // Protection decode of the staged command target
  logic [17:0] tgtAddr;
  logic [17:0] dpEnd;
  logic dpOn;
  logic ppInRange;
  logic ppProt;
  logic dataTarget;
  logic blockErase;
  logic refuse;
  logic [17:0] hiStart;
  logic [17:0] loEnd;
  logic hiHit;
  logic loHit;
  assign tgtAddr = {memAll[1:0], memAll[31:16]};
  assign dataTarget = ctrl_q[flash_protect_pkg::CtrlDataBit];
  assign blockErase = ctrl_q[flash_protect_pkg::CtrlBlkBit];
  assign dpOn = !dataProt_q[flash_protect_pkg::DpOffBit];
  assign dpEnd = flash_protect_pkg::DataFlashBase
               + {6'h00, dataProt_q[3:0], 8'hff};
  assign hiStart = ProgTop - ((18'h00800 << progProt_q[4:3]) - 18'h1);
  assign loEnd = ProgHiBase + ((18'h00400 << progProt_q[1:0]) - 18'h1);
  assign hiHit = !progProt_q[flash_protect_pkg::PpHiDisBit]
               && tgtAddr >= hiStart;
  assign loHit = !progProt_q[flash_protect_pkg::PpLoDisBit]
               && tgtAddr <= loEnd;
  assign ppInRange = tgtAddr >= ProgHiBase;

  always_comb begin
    if (progProt_q[flash_protect_pkg::PpModeBit]) begin
      ppProt = hiHit || loHit;
    end else begin
      ppProt = !(hiHit || loHit);
    end
  end

  always_comb begin
    refuse = 1'b0;
    if (!ctrl_q[flash_protect_pkg::CtrlReqBit]) begin
      refuse = 1'b0;
    end else if (dataTarget) begin
      if (blockErase) begin
        refuse = dpOn;
      end else begin
        refuse = dpOn && tgtAddr >= flash_protect_pkg::DataFlashBase
               && tgtAddr <= dpEnd;
      end
    end else begin
      refuse = ppInRange && ppProt;
    end
  end

  logic launchWr;
  assign launchWr = wrHit && regAddr == flash_protect_pkg::OffStatus
                  && regWrData[flash_protect_pkg::StatCcifBit] && command_complete_flag_q;

  // Command-complete flag and launch handshake
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      command_complete_flag_q <= 1'b1;
      cmdLaunch_q <= 1'b0;
      cmdRefused_q <= 1'b0;
      cmdParams_q <= '0;
    end else begin
      cmdLaunch_q <= 1'b0;
      cmdRefused_q <= 1'b0;
      if (launchWr) begin
        if (refuse) begin
          cmdRefused_q <= 1'b1;
        end else begin
          command_complete_flag_q <= 1'b0;
          cmdLaunch_q <= 1'b1;
          cmdParams_q <= '{code: memAll[15:8], addr: tgtAddr,
                           data0: memAll[47:32]};
        end
      end else if (!command_complete_flag_q && cmdDone) begin
        command_complete_flag_q <= 1'b1;
      end
    end
  end

  // Violation flag: set wins over the write-one clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      viol_q <= 1'b0;
    end else if (launchWr && refuse) begin
      viol_q <= 1'b1;
    end else if (wrHit && regAddr == flash_protect_pkg::OffStatus
                 && regWrData[flash_protect_pkg::StatViolBit]) begin
      viol_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      index_q <= '0;
      ctrl_q <= 8'h00;
    end else if (wrHit && regAddr == flash_protect_pkg::OffIndex) begin
      index_q <= regWrData[Iw-1:0];
    end else if (wrHit && regAddr == flash_protect_pkg::OffCtrl
                 && command_complete_flag_q) begin
      ctrl_q <= regWrData & 8'h07;
    end
  end

  // Array write: software bytes when idle, results when controller posts
  logic [Iw-1:0] memWrAddr;
  logic [1:0] memByteEn;
  logic [15:0] memWrData;
  always_comb begin
    memWrAddr = index_q;
    memByteEn = 2'b00;
    memWrData = {regWrData, regWrData};
    if (!command_complete_flag_q && cmdResult.valid) begin
      memWrAddr = cmdResult.index;
      memByteEn = 2'b11;
      memWrData = cmdResult.data;
    end else if (wrHit && command_complete_flag_q && index_q < Iw'(Nw)) begin
      if (regAddr == flash_protect_pkg::OffCmdHi) begin
        memByteEn = 2'b10;
      end else if (regAddr == flash_protect_pkg::OffCmdLo) begin
        memByteEn = 2'b01;
      end
    end
  end

  cmd_word_mem #(
    .Words(Nw),
    .Width(16),
    .AddrWidth(Iw)
  ) u_mem (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrAddr(memWrAddr),
    .wrByteEn(memByteEn),
    .wrData(memWrData),
    .rdAddr(index_q),
    .rdData(memRd),
    .allWords(memAll)
  );

  // Read path: one-cycle latency; array bytes come from the memory register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdPending_q <= 1'b0;
      rdHighByte_q <= 1'b0;
      rdAddr_q <= 4'h0;
    end else begin
      rdPending_q <= regRead;
      rdHighByte_q <= regAddr == flash_protect_pkg::OffCmdHi;
      rdAddr_q <= regAddr;
    end
  end

  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    unique case (regAddr)
      flash_protect_pkg::OffStatus:
        rdMux = {command_complete_flag_q, 1'b0, viol_q, 5'h00};
      flash_protect_pkg::OffIndex: rdMux = {5'h00, index_q};
      flash_protect_pkg::OffProgProt: rdMux = progProt_q;
      flash_protect_pkg::OffDataProt: rdMux = dataProt_q;
      flash_protect_pkg::OffCtrl: rdMux = ctrl_q;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (regRead) begin
      rdData_q <= rdMux;
    end else begin
      rdData_q <= 8'h00;
    end
  end

  logic isArrayRd;
  assign isArrayRd = rdPending_q
                   && (rdAddr_q == flash_protect_pkg::OffCmdHi
                       || rdAddr_q == flash_protect_pkg::OffCmdLo);
  assign regRdData = isArrayRd
                   ? (rdHighByte_q ? memRd[15:8] : memRd[7:0])
                   : rdData_q;

  assign cmdLaunch = cmdLaunch_q;
  assign cmdParams = cmdParams_q;
  assign cmdRefused = cmdRefused_q;
  assign progProtect = progProt_q;
  assign dataProtect = dataProt_q;
  assign commandComplete = command_complete_flag_q;

endmodule : flash_protect_and_cmd_regs

// ### verification/flash_protect_and_cmd_regs_sva.sv
module flash_protect_and_cmd_regs_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic cfgValid,
  input wire logic cfgFault,
  input wire logic cmdLaunch,
  input wire logic cmdRefused,
  input wire logic cmdDone,
  input wire logic [7:0] progProtect,
  input wire logic [7:0] dataProtect,
  input wire logic commandComplete
);
  timeunit 1ns;
  timeprecision 1ps;
  // Allowed target scenarios, one bit per target
  function automatic logic [7:0] allowTo(input logic [2:0] s);
    case (s)
      3'h0: return 8'h0f;
      3'h1: return 8'h0a;
      3'h2: return 8'h0c;
      3'h3: return 8'h08;
      3'h4: return 8'h18;
      3'h5: return 8'h3c;
      3'h6: return 8'h5a;
      default: return 8'hff;
    endcase
  endfunction : allowTo

  function automatic logic [2:0] scen(input logic [7:0] p);
    return {p[7], p[5], p[2]};
  endfunction : scen

  // Legal move from one protection byte to the next
  function automatic logic okMove(input logic [7:0] p, input logic [7:0] q);
    logic [7:0] row;
    row = allowTo(scen(p));
    return row[scen(q)];
  endfunction : okMove

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_launch_flag: assert property (cmdLaunch |-> !commandComplete)
    else $error("launch with complete flag set");
  a_refuse_flag: assert property
    (cmdRefused |-> commandComplete && !cmdLaunch)
    else $error("refused launch changed state");
  a_launch_write: assert property
    (regWrite && regAddr == 4'h0 && regWrData[7]
    && commandComplete |=> cmdLaunch ^ cmdRefused)
    else $error("status write did not launch or refuse");
  a_flag_hold: assert property
    (!commandComplete && !cmdDone |=> !commandComplete)
    else $error("complete flag rose without done");
  a_flag_done: assert property
    (!commandComplete && cmdDone |=> commandComplete)
    else $error("complete flag not set by done");
  a_prog_tighten: assert property
    (!cfgValid |=> okMove($past(progProtect), progProtect))
    else $error("illegal program protection transition");
  a_data_grow: assert property
    (!cfgValid |=> dataProtect[3:0] >= $past(dataProtect[3:0])
    && !$rose(dataProtect[7]))
    else $error("data protection relaxed");
  a_fault_full: assert property
    (cfgValid && cfgFault |=> dataProtect == 8'h0f)
    else $error("fault load not fully protected");
  a_reserved_zero: assert property
    (regRead && regAddr inside {[4'h6:4'h9]} |=> regRdData == 8'h00)
    else $error("reserved register read not zero");
endmodule : flash_protect_and_cmd_regs_sva

bind flash_protect_and_cmd_regs flash_protect_and_cmd_regs_sva i_sva (
  .ref_clk(ref_clk),
  .rst(rst),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWrite(regWrite),
  .regRead(regRead),
  .regRdData(regRdData),
  .cfgValid(cfgValid),
  .cfgFault(cfgFault),
  .cmdLaunch(cmdLaunch),
  .cmdRefused(cmdRefused),
  .cmdDone(cmdDone),
  .progProtect(progProtect),
  .dataProtect(dataProtect),
  .commandComplete(commandComplete)
);

// ### verification/flash_protect_and_cmd_regs_test.sv
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin badCount++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module flash_protect_and_cmd_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic cfgValid = 1'b0;
  logic [7:0] cfgProgProt = 8'h00;
  logic [7:0] cfgDataProt = 8'h00;
  logic cfgFault = 1'b0;
  flash_protect_pkg::cmd_result_t cmdResult = '0;
  logic cmdDone = 1'b0;
  logic [7:0] regRdData, progProtect, dataProtect;
  logic cmdLaunch, cmdRefused, commandComplete;
  flash_protect_pkg::cmd_launch_t cmdParams;
  int badCount = 0;
  int checked = 0;
  logic [7:0] okTo [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c,
    8'h5a, 8'hff};

  flash_protect_and_cmd_regs i_dut (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .cfgValid(cfgValid), .cfgProgProt(cfgProgProt),
    .cfgDataProt(cfgDataProt), .cfgFault(cfgFault), .cmdLaunch(cmdLaunch),
    .cmdParams(cmdParams), .cmdRefused(cmdRefused), .cmdResult(cmdResult),
    .cmdDone(cmdDone), .progProtect(progProtect), .dataProtect(dataProtect),
    .commandComplete(commandComplete)
  );

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    `CHK("read data", e, regRdData)
  endtask : rd

  task automatic cfg(input logic [7:0] p, input logic [7:0] d, input logic f);
    @(posedge ref_clk);
    cfgProgProt <= p;
    cfgDataProt <= d;
    cfgFault <= f;
    cfgValid <= 1'b1;
    @(posedge ref_clk);
    cfgValid <= 1'b0;
    @(negedge ref_clk);
  endtask : cfg

  task automatic done();
    @(posedge ref_clk);
    cmdDone <= 1'b1;
    @(posedge ref_clk);
    cmdDone <= 1'b0;
    @(negedge ref_clk);
    `CHK("complete flag", 1'b1, commandComplete)
  endtask : done

  // Loads code and address, sets control, launches, judges the outcome
  task automatic pe(input logic [17:0] a, input logic [7:0] ctl,
                    input logic ok);
    wr(4'h1, 8'h00);
    wr(4'h4, 8'h20);
    wr(4'h5, {6'h0, a[17:16]});
    wr(4'h1, 8'h01);
    wr(4'h4, a[15:8]);
    wr(4'h5, a[7:0]);
    wr(4'ha, ctl);
    wr(4'h0, 8'h80);
    @(negedge ref_clk);
    `CHK("launch", ok, cmdLaunch)
    `CHK("refused", !ok, cmdRefused)
    if (ok) begin
      `CHK("code", 8'h20, cmdParams.code)
      `CHK("address", a, cmdParams.addr)
      done();
    end else begin
      rd(4'h0, 8'ha0);
      wr(4'h0, 8'h20);
      rd(4'h0, 8'h80);
    end
  endtask : pe

  function automatic logic [7:0] sb(input logic [2:0] s);
    return {s[2], 1'b0, s[1], 2'b00, s[0], 2'b00};
  endfunction : sb

  task automatic testReset();
    `CHK("prog protect", 8'hff, progProtect)
    `CHK("complete flag", 1'b1, commandComplete)
    rd(4'h0, 8'h80);
    for (int a = 6; a < 10; a++) begin
      wr(4'(a), 8'hff);
      rd(4'(a), 8'h00);
    end
    $display("test reset done");
  endtask : testReset

  task automatic testData();
    cfg(8'hff, 8'h80, 1'b0);
    rd(4'h3, 8'h80);
    pe(18'h04400, 8'h05, 1'b1);
    pe(18'h04400, 8'h07, 1'b1);
    wr(4'h3, 8'h00);
    rd(4'h3, 8'h00);
    pe(18'h044ff, 8'h05, 1'b0);
    pe(18'h04500, 8'h05, 1'b1);
    pe(18'h04400, 8'h07, 1'b0);
    wr(4'h3, 8'h80);
    rd(4'h3, 8'h00);
    wr(4'h3, 8'h03);
    wr(4'h3, 8'h02);
    rd(4'h3, 8'h03);
    cfg(8'hff, 8'h80, 1'b1);
    `CHK("data protect", 8'h0f, dataProtect)
    $display("test data protection done");
  endtask : testData

  task automatic testProg();
    logic [7:0] want;
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        cfg(sb(3'(f)), 8'h0f, 1'b0);
        wr(4'h2, sb(3'(t)));
        @(negedge ref_clk);
        want = okTo[f][t] ? sb(3'(t)) : sb(3'(f));
        `CHK("prog protect", want, progProtect)
      end
    end
    rd(4'h2, 8'ha4);
    wr(4'h2, 8'hbf);
    rd(4'h2, 8'hbf);
    cfg(8'h80, 8'h0f, 1'b0);
    wr(4'h2, 8'h9b);
    rd(4'h2, 8'h80);
    pe(18'h3f800, 8'h01, 1'b0);
    pe(18'h3c000, 8'h01, 1'b1);
    $display("test program protection done");
  endtask : testProg

  task automatic testArray();
    wr(4'h1, 8'h02);
    wr(4'h4, 8'haa);
    wr(4'h5, 8'h55);
    rd(4'h4, 8'haa);
    rd(4'h5, 8'h55);
    wr(4'h1, 8'h06);
    wr(4'h4, 8'hff);
    rd(4'h4, 8'h00);
    rd(4'h5, 8'h00);
    wr(4'h1, 8'h02);
    wr(4'ha, 8'h00);
    wr(4'h0, 8'h80);
    @(negedge ref_clk);
    `CHK("launch", 1'b1, cmdLaunch)
    `CHK("complete flag", 1'b0, commandComplete)
    `CHK("data word", 16'haa55, cmdParams.data0)
    wr(4'h4, 8'h11);
    @(posedge ref_clk);
    cmdResult <= {1'b1, 3'h3, 16'hbeef};
    @(posedge ref_clk);
    cmdResult <= '0;
    done();
    rd(4'h4, 8'haa);
    wr(4'h1, 8'h03);
    rd(4'h4, 8'hbe);
    rd(4'h5, 8'hef);
    $display("test command array done");
  endtask : testArray

  task automatic completeRun();
    $display("checks %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : completeRun

  initial begin
    #200000;
    badCount++;
    completeRun();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    testReset();
    testData();
    testProg();
    testArray();
    completeRun();
  end
endmodule : flash_protect_and_cmd_regs_test
